/* File: shared/ptt_pkg.sv */
// constants and field layout of the periodic tick interval timer
//
// Contract
// - while the gate bit is 0 the tick gets no clock; 1 supplies it.
// - the tick clock gate bit resets to 0, so the block starts unclocked.
// - run 1 starts the tick, run 0 stops it, and run reads 0 after reset.
// - interval code n sets a period of 2^(15-n) slow clock cycles.
// - while running, writes to the interval select field are ignored.
// - a starting write loads the interval; a stopping write keeps it.
// - oscillator loss, stop or deep sleep clears run, keeps the interval.
// - counting needs the slow oscillator running and no deep sleep.
// - hardware raises periodic requests; software counts them into time.
// - the running counter counts slow edges, requesting at each interval.
// - clearing run zeroes the counter and stops it.
package ptt_pkg;

  // ---------------------------------------------------------------------
  // bus
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;

  localparam logic [ADDR_W-1:0] OFS_CLK_GATE  = 12'h0F76;
  localparam logic [ADDR_W-1:0] OFS_TICK_CTRL = 12'h0FC8;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT  = 12'h0FC9;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK  = 12'h0FCA;

  // ---------------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------------
  localparam int BIT_GATE  = 5;
  localparam int BIT_RUN   = 0;
  localparam int SEL_LSB   = 1;
  localparam int SEL_W     = 3;
  localparam int BIT_EVENT = 0;

  localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
  localparam logic [SEL_W-1:0]  RST_SEL  = 3'h0;
  localparam logic [DATA_W-1:0] ZERO_B   = 8'h00;

  // ---------------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------------
  localparam int CNT_W = 15;
  localparam logic [CNT_W-1:0] CNT_ZERO = 15'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 15'h0001;
  localparam logic [CNT_W-1:0] CNT_ALL  = 15'h7FFF;

  typedef enum logic [1:0] {
    PTT_IDLE = 2'b01,
    PTT_RUN  = 2'b10
  } ptt_state_t;

endpackage

/* File: logic/ptt_tick_timer.sv */
// periodic tick interval timer with register port and interrupt
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module ptt_tick_timer
  import ptt_pkg::*;
(
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_reset,
  // register port
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output var  logic [DATA_W-1:0] o_rdata,
  // slow clock and chip mode pins
  input  wire logic              i_slow_clock,
  input  wire logic              i_slow_osc_enable,
  input  wire logic              i_stop_mode,
  input  wire logic              i_deep_sleep_mode,
  // interrupt
  output var  logic              o_tick_irq
);

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  // low bits that must all be ones for the selected span to roll over
  function automatic logic [CNT_W-1:0] span_mask(input logic [SEL_W-1:0] s);
    span_mask = CNT_ALL >> s;
  endfunction

  // ---------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------
  // order: slow clock, osc enable, stop, deep sleep
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  logic       slow_prev_reg;
  logic [3:0] pin_meta_next;
  logic [3:0] pin_sync_next;
  logic       slow_prev_next;

  always_comb begin
    pin_meta_next  = {i_deep_sleep_mode, i_stop_mode,
                      i_slow_osc_enable, i_slow_clock};
    pin_sync_next  = pin_meta_reg;
    slow_prev_next = pin_sync_reg[0];
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pin_meta_reg  <= 4'h0;
      pin_sync_reg  <= 4'h0;
      slow_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg  <= pin_meta_next;
      pin_sync_reg  <= pin_sync_next;
      slow_prev_reg <= slow_prev_next;
    end
  end

  logic slow_rise;
  logic osc_on;
  logic halt_req;
  logic gate_on;

  // ---------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------
  logic [DATA_W-1:0] gate_reg;
  logic [DATA_W-1:0] gate_next;
  logic              run_reg;
  logic              run_next;
  logic [SEL_W-1:0]  sel_reg;
  logic [SEL_W-1:0]  sel_next;
  logic              stat_reg;
  logic              stat_next;
  logic              mask_reg;
  logic              mask_next;
  logic [CNT_W-1:0]  cnt_reg;
  logic [CNT_W-1:0]  cnt_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic              irq_reg;
  logic              irq_next;
  ptt_state_t        state_reg;
  ptt_state_t        state_next;

  logic ctrl_wr;
  logic tick_evt;

  assign gate_on   = gate_reg[BIT_GATE];
  assign slow_rise = gate_on && pin_sync_reg[0] && !slow_prev_reg;
  // no counting without the slow oscillator or in deep sleep
  assign osc_on    = pin_sync_reg[1] && !pin_sync_reg[3];
  assign halt_req  = !pin_sync_reg[1] || pin_sync_reg[2]
                     || pin_sync_reg[3];
  // control writes need the clock supplied, the gate bit is the only door
  assign ctrl_wr   = i_wr && (i_addr == OFS_TICK_CTRL) && gate_on;
  // selected span rolls over on this slow edge
  assign tick_evt  = run_reg && osc_on && slow_rise
                     && ((cnt_reg & span_mask(sel_reg))
                         == span_mask(sel_reg));

  always_comb begin
    gate_next  = gate_reg;
    run_next   = run_reg;
    sel_next   = sel_reg;
    mask_next  = mask_reg;
    stat_next  = stat_reg;
    state_next = state_reg;
    if (i_wr && (i_addr == OFS_CLK_GATE)) begin
      gate_next = i_wdata;
    end
    if (i_wr && (i_addr == OFS_IRQ_MASK)) begin
      mask_next = i_wdata[BIT_EVENT];
    end
    if (ctrl_wr) begin
      run_next = i_wdata[BIT_RUN];
      if (!run_reg) begin
        // interval only loads while stopped, incl. the starting write
        sel_next = i_wdata[SEL_LSB +: SEL_W];
      end
    end
    // only a running tick halts; a start under halt lives one cycle
    if (run_reg && halt_req) begin
      run_next = 1'b0;
    end
    // write-one-to-clear, a new event in the same cycle wins
    if (i_wr && (i_addr == OFS_IRQ_STAT) && i_wdata[BIT_EVENT]) begin
      stat_next = 1'b0;
    end
    if (tick_evt) begin
      stat_next = 1'b1;
    end
    unique case (state_reg)
      PTT_IDLE: begin
        if (run_next) begin
          state_next = PTT_RUN;
        end
      end
      PTT_RUN: begin
        if (!run_next) begin
          state_next = PTT_IDLE;
        end
      end
      default: begin
        state_next = PTT_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------------
  // tick counter
  // ---------------------------------------------------------------------
  always_comb begin
    cnt_next = cnt_reg;
    if (!run_reg) begin
      cnt_next = CNT_ZERO;
    end else if (slow_rise && osc_on) begin
      // free running, wraps without stopping at an event
      cnt_next = cnt_reg + CNT_ONE;
    end
  end

  // ---------------------------------------------------------------------
  // read port and interrupt
  // ---------------------------------------------------------------------
  always_comb begin
    rdata_next = ZERO_B;
    if (i_rd) begin
      unique case (i_addr)
        OFS_CLK_GATE:  rdata_next = gate_reg;
        OFS_TICK_CTRL: begin
          rdata_next               = ZERO_B;
          rdata_next[BIT_RUN]      = run_reg;
          rdata_next[SEL_LSB +: SEL_W] = sel_reg;
        end
        OFS_IRQ_STAT: begin
          rdata_next            = ZERO_B;
          rdata_next[BIT_EVENT] = stat_reg;
        end
        OFS_IRQ_MASK: begin
          rdata_next            = ZERO_B;
          rdata_next[BIT_EVENT] = mask_reg;
        end
        default:       rdata_next = ZERO_B;
      endcase
    end
    irq_next = stat_next && mask_next;
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      gate_reg  <= RST_BYTE;
      run_reg   <= 1'b0;
      sel_reg   <= RST_SEL;
      stat_reg  <= 1'b0;
      mask_reg  <= 1'b0;
      cnt_reg   <= CNT_ZERO;
      rdata_reg <= ZERO_B;
      irq_reg   <= 1'b0;
      state_reg <= PTT_IDLE;
    end else begin
      gate_reg  <= gate_next;
      run_reg   <= run_next;
      sel_reg   <= sel_next;
      stat_reg  <= stat_next;
      mask_reg  <= mask_next;
      cnt_reg   <= cnt_next;
      rdata_reg <= rdata_next;
      irq_reg   <= irq_next;
      state_reg <= state_next;
    end
  end

  assign o_rdata    = rdata_reg;
  assign o_tick_irq = irq_reg;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  gate_stops_count_a: assert property (
    !gate_on && run_reg |=> $stable(cnt_reg) || cnt_reg == CNT_ZERO)
    else $error("counter moved without clock gate");

  run_write_a: assert property (
    ctrl_wr && !halt_req |=> run_reg == $past(i_wdata[BIT_RUN]))
    else $error("run bit did not follow write");

  span_event_a: assert property (
    tick_evt |-> slow_rise && (cnt_reg & span_mask(sel_reg))
                 == span_mask(sel_reg))
    else $error("event outside selected span rollover");

  sel_locked_a: assert property (
    run_reg |=> sel_reg == $past(sel_reg))
    else $error("interval changed while running");

  start_loads_a: assert property (
    ctrl_wr && !run_reg && i_wdata[BIT_RUN] && !halt_req
    |=> run_reg && sel_reg == $past(i_wdata[SEL_LSB +: SEL_W]))
    else $error("starting write did not load interval");

  halt_clears_a: assert property (
    run_reg && halt_req |=> !run_reg && $stable(sel_reg))
    else $error("halt did not clear run");

  cnt_clear_a: assert property (
    !run_reg |=> cnt_reg == CNT_ZERO)
    else $error("counter not cleared when stopped");

  event_irq_a: assert property (
    tick_evt && mask_reg && !(i_wr && i_addr == OFS_IRQ_MASK)
    |=> stat_reg ##0 o_tick_irq[*2])
    else $error("event did not raise interrupt");

  state_track_a: assert property (
    (state_reg == PTT_RUN) == run_reg)
    else $error("state does not track run bit");

  read_run_a: assert property (
    i_rd && i_addr == OFS_TICK_CTRL |=> o_rdata[BIT_RUN] == $past(run_reg))
    else $error("run bit read back wrong");

  gate_blocks_a: assert property (
    i_wr && i_addr == OFS_TICK_CTRL && !gate_on |=> $stable(sel_reg))
    else $error("control write landed without clock gate");

  stop_keeps_a: assert property (
    ctrl_wr && run_reg && !i_wdata[BIT_RUN] |=> !run_reg && $stable(sel_reg))
    else $error("stopping write changed interval");

  count_step_a: assert property (
    run_reg && osc_on && slow_rise && !halt_req && !ctrl_wr
    |=> cnt_reg == $past(cnt_reg) + CNT_ONE)
    else $error("counter missed a slow edge");

  span_wrap_a: assert property (
    tick_evt |=> stat_reg && (cnt_reg & span_mask(sel_reg)) == CNT_ZERO)
    else $error("span bits not zero after event");

  irq_level_a: assert property (
    o_tick_irq == (stat_reg && mask_reg))
    else $error("interrupt level differs from status and mask");

  no_osc_count_a: assert property (
    run_reg && !osc_on |=> ($stable(cnt_reg) || cnt_reg == CNT_ZERO))
    else $error("counter moved without slow oscillator");

  start_cv:  cover property (ctrl_wr && !run_reg && i_wdata[BIT_RUN]);
  event_cv:  cover property (tick_evt ##1 o_tick_irq);
  halt_cv:   cover property (run_reg && halt_req ##1 !run_reg);
  masked_cv: cover property (tick_evt && !mask_reg);
  locked_cv: cover property (ctrl_wr && run_reg);

endmodule

`default_nettype wire

/* File: verification/ptt_tb.sv */
// self-checking testbench for the periodic tick interval timer
`timescale 1ns/1ps
`default_nettype none

module tb;
  import ptt_pkg::*;

  // ---------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------
  logic              i_clk             = 1'b0;
  logic              i_reset           = 1'b1;
  logic [ADDR_W-1:0] i_addr            = '0;
  logic [DATA_W-1:0] i_wdata           = '0;
  logic              i_wr              = 1'b0;
  logic              i_rd              = 1'b0;
  logic [DATA_W-1:0] o_rdata;
  logic              i_slow_clock      = 1'b0;
  logic              i_slow_osc_enable = 1'b1;
  logic              i_stop_mode       = 1'b0;
  logic              i_deep_sleep_mode = 1'b0;
  logic              o_tick_irq;
  logic [2:0]        sel;
  int                n;
  int                errors            = 0;
  int                checked           = 0;

  ptt_tick_timer dut (
    .i_clk             (i_clk),
    .i_reset           (i_reset),
    .i_addr            (i_addr),
    .i_wdata           (i_wdata),
    .i_wr              (i_wr),
    .i_rd              (i_rd),
    .o_rdata           (o_rdata),
    .i_slow_clock      (i_slow_clock),
    .i_slow_osc_enable (i_slow_osc_enable),
    .i_stop_mode       (i_stop_mode),
    .i_deep_sleep_mode (i_deep_sleep_mode),
    .o_tick_irq        (o_tick_irq)
  );

  initial begin
    forever #5 i_clk = ~i_clk;
  end

  // ---------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask

  // slow edges 8 cycles apart, well under a quarter of the bus clock
  task automatic slow(input int k);
    @(posedge i_clk);
    repeat (k) begin
      i_slow_clock <= 1'b1;
      repeat (4) @(posedge i_clk);
      i_slow_clock <= 1'b0;
      repeat (4) @(posedge i_clk);
    end
  endtask

  task automatic irq_wait(input logic exp);
    int i;
    i = 0;
    // sample settled values, never in the launching time step
    #1;
    while (o_tick_irq !== exp && i < 12) begin
      @(posedge i_clk);
      #1;
      i++;
    end
    chk({7'h00, o_tick_irq}, {7'h00, exp});
    if (o_tick_irq !== exp) begin
      complete_run();
    end
  endtask

  // ---------------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge i_clk);
    i_reset <= 1'b0;
    rd(OFS_CLK_GATE, RST_BYTE);
    rd(OFS_TICK_CTRL, RST_BYTE);
    wr(OFS_TICK_CTRL, 8'h0F);
    rd(OFS_TICK_CTRL, RST_BYTE);
    rd(12'h0123, ZERO_B);
    wr(OFS_CLK_GATE, 8'h20);
    rd(OFS_CLK_GATE, 8'h20);
    wr(OFS_IRQ_MASK, 8'h01);
    for (int s = 7; s >= 5; s--) begin
      sel = 3'(s);
      n = 1 << (15 - s);
      wr(OFS_TICK_CTRL, {4'h0, sel, 1'b1});
      rd(OFS_TICK_CTRL, {4'h0, sel, 1'b1});
      wr(OFS_TICK_CTRL, {4'h0, ~sel, 1'b1});
      rd(OFS_TICK_CTRL, {4'h0, sel, 1'b1});
      for (int k = 0; k < 2; k++) begin
        slow(n - 1);
        irq_wait(1'b0);
        slow(1);
        irq_wait(1'b1);
        rd(OFS_IRQ_STAT, 8'h01);
        wr(OFS_IRQ_STAT, 8'h01);
        irq_wait(1'b0);
      end
      wr(OFS_TICK_CTRL, {4'h0, ~sel, 1'b0});
      rd(OFS_TICK_CTRL, {4'h0, sel, 1'b0});
    end
    // masked event, and a restart that must begin from zero
    wr(OFS_IRQ_MASK, ZERO_B);
    wr(OFS_TICK_CTRL, 8'h0F);
    slow(200);
    wr(OFS_TICK_CTRL, 8'h00);
    wr(OFS_TICK_CTRL, 8'h0F);
    slow(255);
    rd(OFS_IRQ_STAT, ZERO_B);
    slow(1);
    irq_wait(1'b0);
    rd(OFS_IRQ_STAT, 8'h01);
    wr(OFS_IRQ_MASK, 8'h01);
    irq_wait(1'b1);
    wr(OFS_IRQ_STAT, 8'h01);
    wr(OFS_TICK_CTRL, 8'h00);
    // each halt source while running
    for (int m = 0; m < 3; m++) begin
      wr(OFS_TICK_CTRL, 8'h0D);
      @(posedge i_clk);
      case (m)
        0: i_slow_osc_enable <= 1'b0;
        1: i_stop_mode <= 1'b1;
        default: i_deep_sleep_mode <= 1'b1;
      endcase
      repeat (6) @(posedge i_clk);
      rd(OFS_TICK_CTRL, 8'h0C);
      wr(OFS_TICK_CTRL, 8'h0F);
      slow(256);
      // stop mode has no counting ban of its own, so only two are judged
      if (m != 1) begin
        rd(OFS_IRQ_STAT, ZERO_B);
      end
      i_slow_osc_enable <= 1'b1;
      i_stop_mode <= 1'b0;
      i_deep_sleep_mode <= 1'b0;
      repeat (4) @(posedge i_clk);
      wr(OFS_TICK_CTRL, 8'h00);
      wr(OFS_IRQ_STAT, 8'h01);
    end
    // gate off only once stopped, then control writes bounce again
    wr(OFS_CLK_GATE, ZERO_B);
    wr(OFS_TICK_CTRL, 8'h0D);
    rd(OFS_TICK_CTRL, ZERO_B);
    // a second reset while running must drop gate and run
    wr(OFS_CLK_GATE, 8'h20);
    wr(OFS_TICK_CTRL, 8'h0F);
    @(posedge i_clk);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    rd(OFS_CLK_GATE, RST_BYTE);
    rd(OFS_TICK_CTRL, RST_BYTE);
    complete_run();
  end

endmodule

`default_nettype wire
